// >>> core/cps_pkg.sv
package cps_pkg;

   // ----------------------------------------------------------------
   // Pin option codes, in config memory order
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OPT_TRI_STATE,
      OPT_DRIVE_1,
      OPT_DRIVE_0,
      OPT_POWER_EN,
      OPT_SLEEP,
      OPT_CLK_FAST,
      OPT_CLK_MID,
      OPT_CLK_SLOW,
      OPT_GPIO,
      OPT_CHARGER,
      OPT_CHARGER_N,
      OPT_WRITE_STROBE,
      OPT_READ_STROBE,
      OPT_BUS_POWER,
      OPT_FRAME_TOGGLE,
      OPT_KEEP_AWAKE
   } cps_option_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      cps_option_t option;
      logic        pulldown_en;
   } cps_cfg_t;

   typedef struct packed {
      logic configured;
      logic suspend;
      logic sof;
      logic charger;
   } cps_usb_t;

   typedef struct packed {
      logic out;
      logic oe_n;
   } cps_pin_t;

   // ----------------------------------------------------------------
   // Levels, widths and reset values
   // ----------------------------------------------------------------
   localparam logic     LVL_HIGH     = 1'b1;
   localparam logic     LVL_LOW      = 1'b0;
   localparam int       DATA_W       = 8;
   localparam int       DIV_W        = 16;
   localparam int       CNT_W        = 8;
   localparam int       CLK_ACC_W    = 16;
   localparam cps_pin_t PIN_RELEASED = '{out: 1'b0, oe_n: 1'b1};

   // ----------------------------------------------------------------
   // Clock rates and output clock phase steps
   // ----------------------------------------------------------------
   localparam longint REF_CLK_HZ  = 200_000_000;
   localparam longint REF_PER_PS  = 5_000;
   localparam longint CLK_FAST_HZ = 24_000_000;
   localparam longint CLK_MID_HZ  = 12_000_000;
   localparam longint CLK_SLOW_HZ = 6_000_000;
   localparam logic [CLK_ACC_W-1:0] CLK_INC_FAST =
      CLK_ACC_W'((2 * CLK_FAST_HZ * (longint'(1) << CLK_ACC_W)) / REF_CLK_HZ);
   localparam logic [CLK_ACC_W-1:0] CLK_INC_MID  =
      CLK_ACC_W'((2 * CLK_MID_HZ * (longint'(1) << CLK_ACC_W)) / REF_CLK_HZ);
   localparam logic [CLK_ACC_W-1:0] CLK_INC_SLOW =
      CLK_ACC_W'((2 * CLK_SLOW_HZ * (longint'(1) << CLK_ACC_W)) / REF_CLK_HZ);

   // ----------------------------------------------------------------
   // Strobe timing (least times, rounded up)
   // ----------------------------------------------------------------
   localparam longint STROBE_NS = 50;
   localparam longint SETTLE_NS = 25;
   localparam logic [CNT_W-1:0] STROBE_CYC =
      CNT_W'((STROBE_NS * 1000 + REF_PER_PS - 1) / REF_PER_PS);
   localparam logic [CNT_W-1:0] SETTLE_CYC =
      CNT_W'((SETTLE_NS * 1000 + REF_PER_PS - 1) / REF_PER_PS);

endpackage

// >>> core/cps_clk_div.sv
// ----------------------------------------------------------------
// Phase-accumulator clock generator
// ----------------------------------------------------------------
// The reference is not an integer multiple of the output rates, so
// the output carries up to one reference period of edge jitter.
module cps_clk_div
   import cps_pkg::*;
#(
   parameter int ACC_W = CLK_ACC_W
)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Control
   input  wire logic             enable,
   input  wire logic [ACC_W-1:0] increment,
   // Clock out
   output logic                  clk_out
);

   logic [ACC_W:0] acc_d;
   logic [ACC_W:0] acc_q;

   // Carry out of the accumulator marks a half period
   always_comb
   begin
      acc_d = {1'b0, acc_q[ACC_W-1:0]} + {1'b0, increment};
   end

   // Stopped clock rests low and restarts from zero phase
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_q   <= '0;
         clk_out <= LVL_LOW;
      end
      else if (!enable)
      begin
         acc_q   <= '0;
         clk_out <= LVL_LOW;
      end
      else
      begin
         acc_q <= acc_d;
         if (acc_d[ACC_W])
            clk_out <= ~clk_out;
      end
   end

endmodule

// >>> core/cps_pin_mux.sv
// Functional notes
// - Tri-state option leaves pin undriven; constant options drive 1 or 0.
// - Power-enable: low once configured, high while suspended.
// - Sleep indicator: low during suspend, high otherwise.
// - Clock options give 24, 12 or 6 MHz, stopped during suspend.
// - GPIO option: pin is one host-controlled input/output bit.
// - Charger option: high when dedicated charger port detected.
// - Inverted charger option drives the complement of charger indication.
// - Write-strobe option: active-low strobe marks each bit-bang data output.
// - Read-strobe option: active-low strobe marks each bit-bang sample.
// - Bus-power option: pin is input, used as attach indication.
// - Frame-toggle option: pin inverts on every start-of-frame.
// - Keep-awake option: active-low input blocks suspend entry.
// - One pin, one function at a time, from the stored option code.
// - Bit-bang enabled: data lines leave normal interface, become 8-bit port.
// - Async bit-bang: bytes presented at a programmable timer rate.
// - Sync bit-bang: lines sampled only after each written byte.
// - During suspend power-enable reads one; optional input pull-down.
module cps_pin_mux
   import cps_pkg::*;
#(
   parameter int DW = DATA_W,
   parameter int TW = DIV_W
)
(
   // Clock and reset
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   // Config memory load
   input  wire logic          cfg_load_valid,
   input  wire cps_cfg_t      cfg_load,
   output logic               cfg_applied,
   // USB engine status
   input  wire cps_usb_t      usb_status,
   // Configurable pin
   input  wire logic          pin_in,
   output logic               pin_out,
   output logic               pin_oe_n,
   // Pin GPIO control
   input  wire logic          gpio_out_value,
   input  wire logic          gpio_drive_en,
   output logic               gpio_in_value,
   // Indications
   output logic               power_enable_n,
   output logic               attach_detect,
   output logic               keep_awake_req,
   output logic               suspend_pulldown,
   // Data lines
   input  wire logic [DW-1:0] data_in,
   output logic      [DW-1:0] data_out,
   output logic      [DW-1:0] data_oe_n,
   // Normal interface side
   input  wire logic [DW-1:0] if_data_out,
   input  wire logic [DW-1:0] if_data_oe_n,
   output logic      [DW-1:0] if_data_in,
   // Bit-bang control and byte streams
   input  wire logic          bb_enable,
   input  wire logic          bb_sync_mode,
   input  wire logic [DW-1:0] bb_dir_mask,
   input  wire logic [TW-1:0] bb_divisor,
   input  wire logic          tx_valid,
   input  wire logic [DW-1:0] tx_data,
   output logic               tx_ready,
   output logic               rx_valid,
   output logic      [DW-1:0] rx_data
);

   typedef enum logic [1:0] {BB_IDLE, BB_WRITE, BB_SETTLE, BB_READ} cps_bb_state_t;

   localparam int RX_LAT_MAX = 64;

   logic            rst_meta_q;
   logic            rst_n;
   logic            pin_meta_q;
   logic            pin_sync_q;
   logic [DW-1:0]   data_meta_q;
   logic [DW-1:0]   data_sync_q;
   logic            applied_q;
   cps_option_t     option_q;
   logic            pulldown_q;
   logic            toggle_q;
   logic            clk_div_out;
   logic            clk_en;
   logic [CLK_ACC_W-1:0] clk_inc;
   cps_pin_t        pin_d;
   cps_pin_t        pin_q;
   logic [TW-1:0]   timer_q;
   logic            tick;
   cps_bb_state_t   bb_state_q;
   logic [CNT_W-1:0] bb_cnt_q;
   logic [DW-1:0]   bb_out_q;
   logic            wr_n_q;
   logic            rd_n_q;
   logic            tx_fire;
   logic            bb_start;
   logic [DW-1:0]   data_out_q;
   logic [DW-1:0]   data_oe_n_q;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic is_clk_opt(input cps_option_t opt);
      return (opt == OPT_CLK_FAST) || (opt == OPT_CLK_MID) || (opt == OPT_CLK_SLOW);
   endfunction

   function automatic logic [CLK_ACC_W-1:0] clk_step(input cps_option_t opt);
      if (opt == OPT_CLK_FAST)
         return CLK_INC_FAST;
      else if (opt == OPT_CLK_MID)
         return CLK_INC_MID;
      else
         return CLK_INC_SLOW;
   endfunction

   // ----------------------------------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------------------------------
   // Two-stage release keeps reset removal clean
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_q <= LVL_LOW;
         rst_n      <= LVL_LOW;
      end
      else
      begin
         rst_meta_q <= LVL_HIGH;
         rst_n      <= rst_meta_q;
      end
   end

   // Pins are asynchronous to the reference clock
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_meta_q  <= LVL_HIGH;
         pin_sync_q  <= LVL_HIGH;
         data_meta_q <= '0;
         data_sync_q <= '0;
      end
      else
      begin
         pin_meta_q  <= pin_in;
         pin_sync_q  <= pin_meta_q;
         data_meta_q <= data_in;
         data_sync_q <= data_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Option load
   // ----------------------------------------------------------------
   // First load after reset wins; later loads are ignored
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         applied_q  <= LVL_LOW;
         option_q   <= OPT_TRI_STATE;
         pulldown_q <= LVL_LOW;
      end
      else if (cfg_load_valid && !applied_q)
      begin
         applied_q  <= LVL_HIGH;
         option_q   <= cfg_load.option;
         pulldown_q <= cfg_load.pulldown_en;
      end
   end

   assign cfg_applied = applied_q;

   // ----------------------------------------------------------------
   // Clock outputs and frame toggle
   // ----------------------------------------------------------------
   assign clk_en  = applied_q && is_clk_opt(option_q) && !usb_status.suspend;
   assign clk_inc = clk_step(option_q);

   cps_clk_div #(
      .ACC_W     (CLK_ACC_W)
   ) u_clk_div (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .enable    (clk_en),
      .increment (clk_inc),
      .clk_out   (clk_div_out)
   );

   // One inversion per start-of-frame pulse
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         toggle_q <= LVL_LOW;
      else if (usb_status.sof)
         toggle_q <= ~toggle_q;
   end

   // ----------------------------------------------------------------
   // Pin function select
   // ----------------------------------------------------------------
   always_comb
   begin
      pin_d = '{out: LVL_LOW, oe_n: LVL_LOW};
      case (option_q)
         OPT_TRI_STATE:    pin_d = PIN_RELEASED;
         OPT_DRIVE_1:      pin_d.out = LVL_HIGH;
         OPT_DRIVE_0:      pin_d.out = LVL_LOW;
         OPT_POWER_EN:     pin_d.out = power_enable_n;
         OPT_SLEEP:        pin_d.out = ~usb_status.suspend;
         OPT_CLK_FAST,
         OPT_CLK_MID,
         OPT_CLK_SLOW:     pin_d.out = clk_div_out;
         OPT_GPIO:         pin_d = '{out: gpio_out_value, oe_n: ~gpio_drive_en};
         OPT_CHARGER:      pin_d.out = usb_status.charger;
         OPT_CHARGER_N:    pin_d.out = ~usb_status.charger;
         OPT_WRITE_STROBE: pin_d.out = wr_n_q;
         OPT_READ_STROBE:  pin_d.out = rd_n_q;
         OPT_BUS_POWER:    pin_d = PIN_RELEASED;
         OPT_FRAME_TOGGLE: pin_d.out = toggle_q;
         OPT_KEEP_AWAKE:   pin_d = PIN_RELEASED;
         default:          pin_d = PIN_RELEASED;
      endcase
      if (!applied_q)
         pin_d = PIN_RELEASED;
   end

   // Registered pin drive avoids glitches on option decode
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_q <= PIN_RELEASED;
      else
         pin_q <= pin_d;
   end

   assign pin_out  = pin_q.out;
   assign pin_oe_n = pin_q.oe_n;

   // ----------------------------------------------------------------
   // Indications
   // ----------------------------------------------------------------
   // Suspend overrides configured, so the indication reads one
   assign power_enable_n = ~usb_status.configured | usb_status.suspend;
   assign gpio_in_value  = pin_sync_q;

   // Input options are only honoured once the code is applied
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         attach_detect    <= LVL_LOW;
         keep_awake_req   <= LVL_LOW;
         suspend_pulldown <= LVL_LOW;
      end
      else
      begin
         attach_detect    <= applied_q && option_q == OPT_BUS_POWER && pin_sync_q;
         keep_awake_req   <= applied_q && option_q == OPT_KEEP_AWAKE && !pin_sync_q;
         suspend_pulldown <= pulldown_q && usb_status.suspend;
      end
   end

   // ----------------------------------------------------------------
   // Bit-bang timer and sequencer
   // ----------------------------------------------------------------
   // Ticks every divisor+1 cycles; ticks during a busy cycle are lost
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         timer_q <= '0;
      else if (!bb_enable || bb_sync_mode || timer_q >= bb_divisor)
         timer_q <= '0;
      else
         timer_q <= timer_q + TW'(1);
   end

   assign tick     = bb_enable && !bb_sync_mode && timer_q >= bb_divisor;
   assign tx_ready = bb_enable && bb_state_q == BB_IDLE && (bb_sync_mode || tick);
   assign tx_fire  = tx_valid && tx_ready;
   assign bb_start = bb_state_q == BB_IDLE && (tx_fire || tick);

   // Write, settle, then sample; async ticks with no byte only sample
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bb_state_q <= BB_IDLE;
         bb_cnt_q   <= '0;
         bb_out_q   <= '0;
         wr_n_q     <= LVL_HIGH;
         rd_n_q     <= LVL_HIGH;
         rx_valid   <= LVL_LOW;
         rx_data    <= '0;
      end
      else
      begin
         rx_valid <= LVL_LOW;
         case (bb_state_q)
            BB_IDLE:
            begin
               if (tx_fire)
               begin
                  bb_out_q   <= tx_data;
                  wr_n_q     <= LVL_LOW;
                  bb_cnt_q   <= STROBE_CYC;
                  bb_state_q <= BB_WRITE;
               end
               else if (bb_start)
               begin
                  rd_n_q     <= LVL_LOW;
                  bb_cnt_q   <= STROBE_CYC;
                  bb_state_q <= BB_READ;
               end
            end
            BB_WRITE:
            begin
               bb_cnt_q <= bb_cnt_q - CNT_W'(1);
               if (bb_cnt_q == CNT_W'(1))
               begin
                  wr_n_q     <= LVL_HIGH;
                  bb_cnt_q   <= SETTLE_CYC;
                  bb_state_q <= BB_SETTLE;
               end
            end
            BB_SETTLE:
            begin
               bb_cnt_q <= bb_cnt_q - CNT_W'(1);
               if (bb_cnt_q == CNT_W'(1))
               begin
                  rd_n_q     <= LVL_LOW;
                  bb_cnt_q   <= STROBE_CYC;
                  bb_state_q <= BB_READ;
               end
            end
            BB_READ:
            begin
               bb_cnt_q <= bb_cnt_q - CNT_W'(1);
               if (bb_cnt_q == CNT_W'(1))
               begin
                  rd_n_q     <= LVL_HIGH;
                  rx_data    <= data_sync_q;
                  rx_valid   <= LVL_HIGH;
                  bb_state_q <= BB_IDLE;
               end
            end
            default:
               bb_state_q <= BB_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Data line ownership
   // ----------------------------------------------------------------
   // Normal interface owns the lines unless bit-bang is on
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         data_out_q  <= '0;
         data_oe_n_q <= '1;
      end
      else if (bb_enable)
      begin
         data_out_q  <= bb_out_q;
         data_oe_n_q <= ~bb_dir_mask;
      end
      else
      begin
         data_out_q  <= if_data_out;
         data_oe_n_q <= if_data_oe_n;
      end
   end

   assign data_out   = data_out_q;
   assign data_oe_n  = data_oe_n_q;
   assign if_data_in = data_sync_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_unloaded_tristate;
      @(posedge ref_clk) disable iff (!rst_n)
      !applied_q |=> pin_oe_n;
   endproperty
   a_unloaded_tristate: assert property (p_unloaded_tristate)
      else $error("pin driven before option applied");

   property p_const_low;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && option_q == OPT_DRIVE_0 |=> !pin_oe_n && !pin_out;
   endproperty
   a_const_low: assert property (p_const_low)
      else $error("constant low option not driven low");

   property p_power_en_suspend;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && option_q == OPT_POWER_EN && usb_status.suspend |=> pin_out && !pin_oe_n;
   endproperty
   a_power_en_suspend: assert property (p_power_en_suspend)
      else $error("power enable not high in suspend");

   property p_sleep_low;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && option_q == OPT_SLEEP |=> pin_out == !$past(usb_status.suspend);
   endproperty
   a_sleep_low: assert property (p_sleep_low)
      else $error("sleep indicator wrong");

   property p_clk_stopped;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && is_clk_opt(option_q) && usb_status.suspend [*2] |=> !pin_out;
   endproperty
   a_clk_stopped: assert property (p_clk_stopped)
      else $error("clock output running in suspend");

   property p_charger_inv;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && option_q == OPT_CHARGER_N |=> pin_out != $past(usb_status.charger);
   endproperty
   a_charger_inv: assert property (p_charger_inv)
      else $error("inverted charger level wrong");

   property p_frame_toggle;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && option_q == OPT_FRAME_TOGGLE && usb_status.sof
         |=> ##1 pin_out != $past(pin_out);
   endproperty
   a_frame_toggle: assert property (p_frame_toggle)
      else $error("frame toggle missed");

   property p_keep_awake;
      @(posedge ref_clk) disable iff (!rst_n)
      applied_q && option_q == OPT_KEEP_AWAKE && !pin_sync_q |=> keep_awake_req;
   endproperty
   a_keep_awake: assert property (p_keep_awake)
      else $error("keep awake not raised");

   property p_released;
      @(posedge ref_clk) disable iff (!rst_n)
      rst_n && !bb_enable |=> data_oe_n == $past(if_data_oe_n);
   endproperty
   a_released: assert property (p_released)
      else $error("data lines not with normal interface");

   property p_write_strobe;
      @(posedge ref_clk) disable iff (!rst_n)
      !wr_n_q |-> bb_state_q == BB_WRITE;
   endproperty
   a_write_strobe: assert property (p_write_strobe)
      else $error("write strobe outside write phase");

   property p_sync_sample;
      @(posedge ref_clk) disable iff (!rst_n)
      tx_fire && bb_sync_mode |=> !rx_valid [*1] ##[1:RX_LAT_MAX] rx_valid;
   endproperty
   a_sync_sample: assert property (p_sync_sample)
      else $error("no sample after written byte");

   c_async_tick: cover property (@(posedge ref_clk) disable iff (!rst_n) tick && tx_fire);
   c_sync_rx:    cover property (@(posedge ref_clk) disable iff (!rst_n) bb_sync_mode && rx_valid);
   c_clk_run:    cover property (@(posedge ref_clk) disable iff (!rst_n) clk_en && pin_out);
   c_attach:     cover property (@(posedge ref_clk) disable iff (!rst_n) attach_detect);

endmodule

// >>> test/cps_board.sv
module cps_board
   import cps_pkg::*;
(
   // Device side of the pin and data lines
   input  wire logic       pin_out,
   input  wire logic       pin_oe_n,
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe_n,
   // Board drive of the pin
   input  wire logic       drv_en,
   input  wire logic       drv_val,
   // Levels seen by the device
   output logic            pin_in,
   output logic      [7:0] data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pull-up holds a released pin high; device drive wins over board
   assign pin_in = !pin_oe_n ? pin_out : (drv_en ? drv_val : LVL_HIGH);
   // Board pattern on every released line, so a stale value cannot pass
   assign data_in = (data_out & ~data_oe_n) | (8'h5a & data_oe_n);
endmodule

// >>> test/tb.sv
module tb
   import cps_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic       ref_clk = 0, arst_n = 0, cfg_load_valid = 0, drv_en = 0, drv_val = 0;
   logic       gpio_out_value = 0, gpio_drive_en = 0, bb_enable = 0, bb_sync_mode = 0;
   logic       tx_valid = 0, cfg_applied, pin_in, pin_out, pin_oe_n, gpio_in_value;
   logic       power_enable_n, attach_detect, keep_awake_req, suspend_pulldown;
   logic       tx_ready, rx_valid;
   logic [7:0] data_in, data_out, data_oe_n, if_data_in, rx_data;
   logic [7:0] if_data_out = 8'h3c, if_data_oe_n = 8'h00, bb_dir_mask = 8'h0f, tx_data = 0;
   logic [15:0] bb_divisor = 16'h0027;
   cps_cfg_t   cfg_load = '0;
   cps_usb_t   usb_status = '0;
   int         mismatches = 0, checks = 0, lo, ri, pu;

   cps_pin_mux u_dut (.ref_clk, .arst_n, .cfg_load_valid, .cfg_load, .cfg_applied,
      .usb_status, .pin_in, .pin_out, .pin_oe_n, .gpio_out_value, .gpio_drive_en,
      .gpio_in_value, .power_enable_n, .attach_detect, .keep_awake_req, .suspend_pulldown,
      .data_in, .data_out, .data_oe_n, .if_data_out, .if_data_oe_n, .if_data_in,
      .bb_enable, .bb_sync_mode, .bb_dir_mask, .bb_divisor, .tx_valid, .tx_data,
      .tx_ready, .rx_valid, .rx_data);
   cps_board u_board (.pin_out, .pin_oe_n, .data_out, .data_oe_n, .drv_en, .drv_val,
      .pin_in, .data_in);

   // Free-running 200 MHz reference
   initial
   begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Reset for 5 cycles, then one option load at the third edge after release
   task automatic boot(input cps_option_t o);
      arst_n = 0;
      cyc(5);
      chk("oe_rst", pin_oe_n, 1'b1);
      arst_n = 1;
      cyc(3);
      cfg_load_valid = 1;
      cfg_load = '{option: o, pulldown_en: 1'b1};
      cyc(1);
      cfg_load_valid = 0;
      cyc(3);
      chk("applied", cfg_applied, 1'b1);
   endtask

   // Counts low cycles, rising edges of the pin and sample pulses
   task automatic watch(input int n);
      logic p;
      p = pin_out;
      lo = 0;
      ri = 0;
      pu = 0;
      repeat (n)
      begin
         cyc(1);
         lo += !pin_out;
         ri += pin_out && !p;
         pu += rx_valid;
         p = pin_out;
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_fixed();
      for (int i = 0; i < 3; i++)
      begin
         boot(cps_option_t'(i));
         chk("oe", pin_oe_n, i == 0);
         if (i > 0) chk("lvl", pin_out, i == 1);
      end
      cfg_load_valid = 1;
      cfg_load.option = OPT_DRIVE_1;
      cyc(4);
      cfg_load_valid = 0;
      chk("reload", pin_out, 1'b0);
      chk("pass", data_out, 8'h3c);
      chk("pass_in", if_data_in, 8'h3c);
      $display("fixed levels done");
   endtask

   task automatic t_power();
      boot(OPT_POWER_EN);
      usb_status = '{configured: 1, suspend: 0, sof: 0, charger: 1};
      cyc(2);
      chk("pwr_on", pin_out, 1'b0);
      usb_status.suspend = 1;
      cyc(2);
      chk("pwr_susp", {pin_out, power_enable_n, suspend_pulldown}, 3'h7);
      boot(OPT_SLEEP);
      chk("sleep", pin_out, 1'b0);
      usb_status.suspend = 0;
      cyc(2);
      chk("awake", pin_out, 1'b1);
      boot(OPT_CHARGER);
      chk("chg", {pin_oe_n, pin_out}, 2'b01);
      boot(OPT_CHARGER_N);
      chk("chg_n", pin_out, 1'b0);
      $display("power and charger done");
   endtask

   task automatic t_pin_io();
      boot(OPT_GPIO);
      gpio_out_value = 1;
      gpio_drive_en = 1;
      cyc(2);
      chk("gpio_drv", {pin_oe_n, pin_out}, 2'b01);
      gpio_drive_en = 0;
      drv_en = 1;
      cyc(4);
      chk("gpio_in", {pin_oe_n, gpio_in_value}, 2'b10);
      boot(OPT_BUS_POWER);
      drv_val = 1;
      cyc(4);
      chk("attach", {pin_oe_n, attach_detect}, 2'b11);
      boot(OPT_KEEP_AWAKE);
      drv_val = 0;
      cyc(4);
      chk("keep", {pin_oe_n, keep_awake_req}, 2'b11);
      drv_en = 0;
      boot(OPT_FRAME_TOGGLE);
      repeat (2)
      begin
         drv_val = pin_out;
         usb_status.sof = 1;
         cyc(1);
         usb_status.sof = 0;
         cyc(3);
         chk("toggle", pin_out, !drv_val);
      end
      $display("pin io done");
   endtask

   // Rising edges in 1000 cycles (5 us): 120, 60, 30 give or take two
   task automatic t_clocks();
      for (int i = 0; i < 3; i++)
      begin
         boot(cps_option_t'(int'(OPT_CLK_FAST) + i));
         watch(1000);
         chk("rate", ri >= (120 >> i) - 2 && ri <= (120 >> i) + 2, 1'b1);
         usb_status.suspend = 1;
         cyc(3);
         watch(100);
         chk("stopped", ri, 16'h0);
         usb_status.suspend = 0;
      end
      $display("clocks done");
   endtask

   task automatic t_bitbang();
      boot(OPT_WRITE_STROBE);
      bb_enable = 1;
      bb_sync_mode = 1;
      cyc(2);
      chk("ready", tx_ready, 1'b1);
      tx_valid = 1;
      tx_data = 8'hc3;
      cyc(1);
      tx_valid = 0;
      watch(40);
      chk("wr_low", lo, 16'd10);
      chk("sample", {rx_data, data_out, data_oe_n}, 24'h53c3f0);
      chk("one_rx", pu, 16'h1);
      boot(OPT_READ_STROBE);
      bb_sync_mode = 0;
      // Ten ticks 40 cycles apart; the last sample lands at cycle 410
      watch(410);
      chk("ticks", pu, 16'd10);
      chk("rd_low", lo, 16'd100);
      // Async byte is only taken in a tick cycle, so hold it until ready
      tx_data = 8'ha5;
      tx_valid = 1;
      while (!tx_ready)
         cyc(1);
      cyc(1);
      tx_valid = 0;
      cyc(30);
      chk("async_out", {rx_data, data_out}, 16'h55a5);
      bb_enable = 0;
      $display("bit-bang done");
   endtask

   // Watchdog: all scenarios fit well within 40000 cycles
   initial
   begin
      #200us;
      mismatches++;
      give_verdict();
   end

   initial
   begin
      t_fixed();
      t_power();
      t_pin_io();
      t_clocks();
      t_bitbang();
      give_verdict();
   end
endmodule
